// *** inc/btcp_pkg.sv ***
// Constants and types for the backlight tuning and charge pump register slice
`default_nettype none
package btcp_pkg;
  localparam logic [7:0] ADDR_BOOST_TRIM = 8'h0a;
  localparam logic [7:0] ADDR_PUMP_CFG   = 8'h0b;
  localparam logic [7:0] ADDR_CHK_LOW    = 8'h0c;
  localparam logic [7:0] ADDR_CHK_HIGH   = 8'h0d;
  localparam int unsigned NV_ENTRIES     = 12;
  localparam logic [3:0] NV_LAST_IDX     = 4'hb;
  localparam logic [3:0] NV_IDX_BOOST    = 4'ha;
  localparam logic [3:0] NV_IDX_PUMP     = 4'hb;
  localparam logic [7:0] BOOST_TRIM_RST  = 8'h70;
  localparam logic [7:0] PUMP_CFG_RST    = 8'h00;
  // Factory image, entry 0 in the low byte
  localparam logic [95:0] NV_FACTORY_IMAGE = {PUMP_CFG_RST, BOOST_TRIM_RST, 80'h0};
  // Field positions
  localparam int unsigned BOOST_CODE_MSB = 7;
  localparam int unsigned BOOST_CODE_LSB = 4;
  localparam int unsigned TRIM_MSB       = 3;
  localparam int unsigned TRIM_LSB       = 0;
  localparam int unsigned RATIO_AUTO_DIS = 7;
  localparam int unsigned RATIO_FIX_SEL  = 6;
  localparam int unsigned FREQ_TRAN_MODE = 3;
  localparam int unsigned FREQ_FIX_SEL   = 2;
  localparam int unsigned FREQ_DIV_MSB   = 1;
  localparam int unsigned FREQ_DIV_LSB   = 0;
  // Scaling: millivolts and hundredths of a percent
  localparam logic [15:0] BOOST_BASE_MV  = 16'h35b6;
  localparam logic [15:0] BOOST_STEP_MV  = 16'h08de;
  localparam logic [9:0]  TRIM_STEP_CPCT = 10'h033;
  // Brightness thresholds on a 12-bit scale: 75% and 50%
  localparam logic [11:0] BRIGHT_75      = 12'hc00;
  localparam logic [11:0] BRIGHT_50      = 12'h800;
  // Pump divider output codes
  localparam logic [1:0]  DIV_HALF       = 2'h0;
  localparam logic [1:0]  DIV_QUARTER    = 2'h1;
  localparam logic [1:0]  DIV_EIGHTH     = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_LOAD   = 4'h2,
    ST_PROG_A = 4'h4,
    ST_PROG_B = 4'h8
  } btcp_state_t;
endpackage
`default_nettype wire

// *** inc/btcp_nv_if.sv ***
// Carrier between the register slice and its nonvolatile store
`timescale 1ns/100ps
`default_nettype none
interface btcp_nv_if;
  logic [3:0] rdAddr;
  logic [7:0] rdData;
  logic       wrEn;
  logic [3:0] wrAddr;
  logic [7:0] wrData;
  modport ctrl  (output rdAddr, output wrEn, output wrAddr, output wrData, input rdData);
  modport store (input rdAddr, input wrEn, input wrAddr, input wrData, output rdData);
endinterface
`default_nettype wire

// *** logic/btcp_nv_store.sv ***
// Nonvolatile image of registers 0x00 to 0x0b with registered read data
`timescale 1ns/100ps
`default_nettype none
module btcp_nv_store
  import btcp_pkg::*;
(
  // Clock and reset
  input wire logic   ref_clk,
  input wire logic   nrst,
  // Store port
  btcp_nv_if.store   nv
);
  logic [7:0] mem_q [NV_ENTRIES];
  genvar gi;
  generate
    for (gi = 0; gi < NV_ENTRIES; gi++)
    begin : gEntry
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          mem_q[gi] <= NV_FACTORY_IMAGE[8*gi +: 8];
        else if (nv.wrEn && nv.wrAddr == 4'(gi))
          mem_q[gi] <= nv.wrData;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      nv.rdData <= 8'h00;
    else if (nv.rdAddr <= NV_LAST_IDX)
      nv.rdData <= mem_q[nv.rdAddr];
    else
      nv.rdData <= 8'h00;
  end
endmodule
`default_nettype wire

// *** logic/btcp_config_regs.sv ***
// Boost target, current trim, charge pump configuration and checksum registers
// Contract
// R1: Bits 7:4 are boost target code, 13.75V plus 2.27V per step, default 0111.
// R2: Bits 3:0 raise full-scale current about 0.51% per code, default 0000.
// R3: Pump bit 7 clear picks 2x/3x automatically; set follows fixed select.
// R4: Bit 6 counts only with bit 7 set: 0 forces 2x, 1 forces 3x.
// R5: Mode bit 3 clear steps at 75% and 50%; set steps at 50% only.
// R6: Mode 0 with bit 2 set: fixed divider 1/2, 1/4, 1/8, 1/8.
// R7: Mode 1 ignores bit 2; divider bit 0 picks 1/2-1/4 or 1/4-1/8 pair.
// R8: Low checksum byte is read-only sum over registers 0x00 to 0x0b.
// R9: Stored values load despite bad user checksum when factory checksum is good.
// R10: Checksum refreshes only after enable toggle or power cycle following programming.
// R11: Power-on values 0x70 and 0x00 come from the nonvolatile defaults.
// R12: High checksum byte is read-only at address 0x0d.
// R13: Checksum writes are ignored; reserved pump bits 5:4 have no effect.
`timescale 1ns/100ps
`default_nettype none
module btcp_config_regs
  import btcp_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Register access from the serial engine
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRdEn,
  output var  logic [7:0]  regRdData,
  // Nonvolatile control and pins
  input  wire logic        nvProgReq,
  input  wire logic        enPin,
  input  wire logic        factoryChkOk,
  // Operating state from the analog side
  input  wire logic [11:0] ledBrightness,
  input  wire logic        pumpNeeds3x,
  // Settings to the analog side and load busy status
  output var  logic [15:0] boostTargetMv,
  output var  logic [9:0]  currentTrimCpct,
  output var  logic        pumpRatio3x,
  output var  logic [1:0]  pumpDivCode,
  output var  logic        loadBusy
);
  btcp_nv_if nv ();
  btcp_nv_store uStore (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .nv      (nv)
  );

  btcp_state_t state_q;
  logic [7:0]  boostTrim_q;
  logic [7:0]  pumpCfg_q;
  logic [15:0] chkSum_q;
  logic [15:0] sumAcc_q;
  logic [3:0]  ldCnt_q;
  logic        ldDataValid_q;
  logic        enSync1_q;
  logic        enSync2_q;
  logic        enSync3_q;
  logic        enLevel_q;
  logic        enRise;
  logic        hostWrBoost;
  logic        hostWrPump;
  logic [3:0]  ldIdx;

  // Enable pin synchroniser; edge counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enSync1_q <= 1'b0;
      enSync2_q <= 1'b0;
      enSync3_q <= 1'b0;
      enLevel_q <= 1'b0;
    end
    else
    begin
      enSync1_q <= enPin;
      enSync2_q <= enSync1_q;
      enSync3_q <= enSync2_q;
      if (enSync2_q == enSync3_q)
        enLevel_q <= enSync3_q;
    end
  end
  assign enRise = (enSync2_q == enSync3_q) && enSync3_q && !enLevel_q;

  assign hostWrBoost = regWrEn && regAddr == ADDR_BOOST_TRIM && state_q != ST_LOAD;
  assign hostWrPump  = regWrEn && regAddr == ADDR_PUMP_CFG && state_q != ST_LOAD;
  assign ldIdx       = ldCnt_q - 4'h1;

  // Load, programming sequencer
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q       <= ST_LOAD;
      ldCnt_q       <= 4'h0;
      ldDataValid_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          ldCnt_q       <= 4'h0;
          ldDataValid_q <= 1'b0;
          if (enRise)
            state_q <= ST_LOAD;   // R10
          else if (nvProgReq)
            state_q <= ST_PROG_A;
        end
        ST_LOAD:
        begin
          ldDataValid_q <= 1'b1;
          ldCnt_q       <= ldCnt_q + 4'h1;
          if (ldDataValid_q && ldIdx == NV_LAST_IDX)
            state_q <= ST_IDLE;
        end
        ST_PROG_A:
          state_q <= ST_PROG_B;
        ST_PROG_B:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    nv.rdAddr = ldCnt_q;
    nv.wrEn   = (state_q == ST_PROG_A) || (state_q == ST_PROG_B);
    nv.wrAddr = (state_q == ST_PROG_A) ? NV_IDX_BOOST : NV_IDX_PUMP;
    nv.wrData = (state_q == ST_PROG_A) ? boostTrim_q : pumpCfg_q;
  end

  // Checksum accumulates during load and publishes only at its end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sumAcc_q <= 16'h0000;
      chkSum_q <= 16'h0000;
    end
    else if (state_q == ST_LOAD && ldDataValid_q)
    begin
      sumAcc_q <= sumAcc_q + {8'h00, nv.rdData};                // R8
      if (ldIdx == NV_LAST_IDX)
        chkSum_q <= sumAcc_q + {8'h00, nv.rdData};              // R10 R12
    end
    else if (state_q == ST_IDLE)
      sumAcc_q <= 16'h0000;
  end

  // Live registers; reserved pump bits are stored and read back only
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      boostTrim_q <= BOOST_TRIM_RST;                            // R11
      pumpCfg_q   <= PUMP_CFG_RST;                              // R11
    end
    else if (state_q == ST_LOAD && ldDataValid_q && factoryChkOk)
    begin
      if (ldIdx == NV_IDX_BOOST)
        boostTrim_q <= nv.rdData;                               // R9 R11
      if (ldIdx == NV_IDX_PUMP)
        pumpCfg_q <= nv.rdData;                                 // R9
    end
    else
    begin
      if (hostWrBoost)
        boostTrim_q <= regWrData;
      if (hostWrPump)
        pumpCfg_q <= regWrData;                                 // R13
    end
  end

  // Read port; checksum bytes have no write path
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 8'h00;
    else if (regRdEn)
    begin
      case (regAddr)
        ADDR_BOOST_TRIM: regRdData <= boostTrim_q;
        ADDR_PUMP_CFG:   regRdData <= pumpCfg_q;
        ADDR_CHK_LOW:    regRdData <= chkSum_q[7:0];            // R8 R13
        ADDR_CHK_HIGH:   regRdData <= chkSum_q[15:8];           // R12
        default:         regRdData <= 8'h00;
      endcase
    end
  end

  // Boost target and current trim scaling
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      boostTargetMv   <= 16'h0000;
      currentTrimCpct <= 10'h000;
    end
    else
    begin
      boostTargetMv <= 16'(BOOST_BASE_MV
        + BOOST_STEP_MV * {12'h000, boostTrim_q[BOOST_CODE_MSB:BOOST_CODE_LSB]});  // R1
      currentTrimCpct <= 10'(TRIM_STEP_CPCT
        * {6'h00, boostTrim_q[TRIM_MSB:TRIM_LSB]});                               // R2
    end
  end

  // Charge pump ratio
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pumpRatio3x <= 1'b0;
    else if (!pumpCfg_q[RATIO_AUTO_DIS])
      pumpRatio3x <= pumpNeeds3x;                               // R3
    else
      pumpRatio3x <= pumpCfg_q[RATIO_FIX_SEL];                  // R4
  end

  // Charge pump divider against brightness
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pumpDivCode <= DIV_HALF;
    else if (pumpCfg_q[FREQ_TRAN_MODE])
    begin
      if (!pumpCfg_q[FREQ_DIV_LSB])                             // R7
        pumpDivCode <= (ledBrightness >= BRIGHT_50) ? DIV_HALF : DIV_QUARTER;
      else
        pumpDivCode <= (ledBrightness >= BRIGHT_50) ? DIV_QUARTER : DIV_EIGHTH;
    end
    else if (pumpCfg_q[FREQ_FIX_SEL])
    begin
      case (pumpCfg_q[FREQ_DIV_MSB:FREQ_DIV_LSB])               // R6
        2'h0:    pumpDivCode <= DIV_HALF;
        2'h1:    pumpDivCode <= DIV_QUARTER;
        default: pumpDivCode <= DIV_EIGHTH;
      endcase
    end
    else if (ledBrightness >= BRIGHT_75)
      pumpDivCode <= DIV_HALF;                                  // R5
    else if (ledBrightness >= BRIGHT_50)
      pumpDivCode <= DIV_QUARTER;
    else
      pumpDivCode <= DIV_EIGHTH;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      loadBusy <= 1'b1;
    else
      loadBusy <= (state_q == ST_LOAD);
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  AST_BOOST_SCALE: assert property (boostTrim_q[7:4] == 4'h7 |=> boostTargetMv == 16'd29640) // R1
    else $error("boost target not scaled from code");
  AST_TRIM_SCALE: assert property (boostTrim_q[3:0] == 4'h1 |=> currentTrimCpct == 10'd51) // R2
    else $error("current trim not scaled from code");
  AST_RATIO_AUTO: assert property (!pumpCfg_q[7] && $stable(pumpCfg_q) |=> pumpRatio3x == $past(pumpNeeds3x)) // R3
    else $error("automatic ratio not following conditions");
  AST_RATIO_FIXED: assert property (pumpCfg_q[7] |=> pumpRatio3x == $past(pumpCfg_q[6])) // R4
    else $error("fixed ratio not following select bit");
  AST_FREQ_AUTO: assert property (pumpCfg_q[3:2] == 2'b00 && ledBrightness < BRIGHT_50 |=> pumpDivCode == DIV_EIGHTH) // R5
    else $error("automatic stepping wrong below half brightness");
  AST_FREQ_FIXED: assert property (pumpCfg_q[3:0] == 4'b0111 |=> pumpDivCode == DIV_EIGHTH) // R6
    else $error("fixed divider code wrong");
  AST_FREQ_MODE1: assert property (pumpCfg_q[3] && pumpCfg_q[0] && ledBrightness >= BRIGHT_50 |=> pumpDivCode == DIV_QUARTER) // R7
    else $error("transition mode pair wrong");
  AST_CHK_NO_WRITE: assert property (state_q == ST_IDLE && regWrEn && regAddr == ADDR_CHK_LOW |=> $stable(chkSum_q)) // R13
    else $error("checksum changed by host write");
  AST_CHK_ONLY_LOAD: assert property (!$stable(chkSum_q) |-> $past(state_q) == ST_LOAD) // R10
    else $error("checksum changed outside reload");
  AST_LOAD_ON_EN: assert property (state_q == ST_IDLE && enRise |=> state_q == ST_LOAD ##[12:13] state_q == ST_IDLE) // R10
    else $error("enable rise did not run a bounded reload");
  AST_LOAD_GATED: assert property (state_q == ST_LOAD && ldDataValid_q && ldIdx == NV_IDX_PUMP && factoryChkOk |=> pumpCfg_q == $past(nv.rdData)) // R9
    else $error("stored pump value not loaded");
endmodule
`default_nettype wire

// *** test/btcp_host_model.sv ***
// Host model driving the register port, programming request and enable pin
`timescale 1ns/100ps
`default_nettype none
module btcp_host_model
(
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output var  logic [7:0] regAddr,
  output var  logic       regWrEn,
  output var  logic [7:0] regWrData,
  output var  logic       regRdEn,
  input  wire logic [7:0] regRdData,
  // Store control and pin
  output var  logic       nvProgReq,
  output var  logic       enPin,
  input  wire logic       loadBusy
);
  initial
  begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
    nvProgReq = 1'b0;
    enPin = 1'b0;
  end

  // Released bus lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask

  task automatic prog();
    @(negedge ref_clk);
    nvProgReq = 1'b1;
    @(negedge ref_clk);
    nvProgReq = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  // Enable toggle before trusting the checksum
  task automatic cycleEnable(output logic ok);
    logic sawBusy;
    sawBusy = 1'b0;
    @(negedge ref_clk);
    enPin = 1'b1;
    repeat (60)
    begin
      @(negedge ref_clk);
      if (loadBusy === 1'b1) sawBusy = 1'b1;
      else if (sawBusy) break;
    end
    ok = sawBusy && (loadBusy === 1'b0);
    enPin = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** test/test_btcp_config_regs.sv ***
// Self-checking bench for the configuration register slice
`timescale 1ns/100ps
`default_nettype none
module test_btcp_config_regs
  import btcp_pkg::*;
();
  logic        ref_clk, nrst, regWrEn, regRdEn, nvProgReq, enPin, loadBusy;
  logic        factoryChkOk, pumpNeeds3x, pumpRatio3x, ok;
  logic [7:0]  regAddr, regWrData, regRdData, v, a, b;
  logic [11:0] ledBrightness;
  logic [15:0] boostTargetMv;
  logic [9:0]  currentTrimCpct;
  logic [1:0]  pumpDivCode;
  logic [11:0] levels [4] = '{BRIGHT_75, BRIGHT_75 - 12'h001, BRIGHT_50, BRIGHT_50 - 12'h001};
  int          bad_count = 0;
  int          cmp_count = 0;

  btcp_config_regs i_btcp_config_regs (.ref_clk, .nrst, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .nvProgReq, .enPin, .factoryChkOk, .ledBrightness, .pumpNeeds3x,
    .boostTargetMv, .currentTrimCpct, .pumpRatio3x, .pumpDivCode, .loadBusy);
  btcp_host_model i_btcp_host_model (.ref_clk, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .nvProgReq, .enPin, .loadBusy);

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    i_btcp_host_model.rd(ad, d);
    cmp_count++;
    if (d !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t read %h got %h exp %h", $time, ad, d, exp);
    end
  endtask

  function automatic logic [15:0] expMv(input logic [7:0] r);
    return BOOST_BASE_MV + BOOST_STEP_MV * 16'(r[7:4]);
  endfunction

  function automatic logic [1:0] expDiv(input logic [7:0] c, input logic [11:0] br);
    if (c[FREQ_TRAN_MODE])
      return c[0] ? (br >= BRIGHT_50 ? DIV_QUARTER : DIV_EIGHTH)
                  : (br >= BRIGHT_50 ? DIV_HALF : DIV_QUARTER);
    if (c[FREQ_FIX_SEL])
      return c[1] ? DIV_EIGHTH : (c[0] ? DIV_QUARTER : DIV_HALF);
    return br >= BRIGHT_75 ? DIV_HALF : (br >= BRIGHT_50 ? DIV_QUARTER : DIV_EIGHTH);
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #(20 * 20000);
    bad_count++;
    conclude();
  end

  initial
  begin
    nrst = 1'b0;
    factoryChkOk = 1'b1;
    ledBrightness = 12'h000;
    pumpNeeds3x = 1'b0;
    void'($urandom(62633));
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    repeat (40) if (loadBusy !== 1'b0) @(negedge ref_clk);
    rdChk(ADDR_BOOST_TRIM, BOOST_TRIM_RST);
    rdChk(ADDR_PUMP_CFG, PUMP_CFG_RST);
    rdChk(ADDR_CHK_LOW, 8'h70);
    rdChk(ADDR_CHK_HIGH, 8'h00);
    rdChk(8'h20, 8'h00);
    checkVal(boostTargetMv, expMv(BOOST_TRIM_RST), "boost");
    // Boost code and trim, extremes first
    for (int i = 0; i < 20; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h71 : 8'($urandom);
      i_btcp_host_model.wr(ADDR_BOOST_TRIM, v);
      repeat (2) @(negedge ref_clk);
      checkVal(boostTargetMv, expMv(v), "boost");
      checkVal(16'(currentTrimCpct), 16'(TRIM_STEP_CPCT * 10'(v[3:0])), "trim");
      rdChk(ADDR_BOOST_TRIM, v);
    end
    // Every ratio and frequency mode against brightness corners
    for (int i = 0; i < 64; i++)
    begin
      v = {i[3], i[2], 2'($urandom), i[1], i[0], 2'($urandom)};
      @(negedge ref_clk);
      ledBrightness = (i % 5 == 4) ? 12'($urandom) : levels[i[5:4]];
      pumpNeeds3x = 1'($urandom);
      i_btcp_host_model.wr(ADDR_PUMP_CFG, v);
      repeat (2) @(negedge ref_clk);
      checkVal(16'(pumpRatio3x), 16'(v[7] ? v[6] : pumpNeeds3x), "ratio");
      checkVal(16'(pumpDivCode), 16'(expDiv(v, ledBrightness)), "div");
      rdChk(ADDR_PUMP_CFG, v);
    end
    // Checksum bytes refuse writes
    i_btcp_host_model.wr(ADDR_CHK_LOW, 8'h55);
    i_btcp_host_model.wr(ADDR_CHK_HIGH, 8'haa);
    rdChk(ADDR_CHK_LOW, 8'h70);
    rdChk(ADDR_CHK_HIGH, 8'h00);
    // Programming, stale checksum until the enable toggle
    a = 8'($urandom) | 8'h80;
    b = 8'($urandom) | 8'h80;
    i_btcp_host_model.wr(ADDR_BOOST_TRIM, a);
    i_btcp_host_model.wr(ADDR_PUMP_CFG, b);
    i_btcp_host_model.prog();
    rdChk(ADDR_CHK_LOW, 8'h70);
    i_btcp_host_model.wr(ADDR_BOOST_TRIM, ~a);
    i_btcp_host_model.cycleEnable(ok);
    checkVal(16'(ok), 16'h0001, "reload");
    rdChk(ADDR_BOOST_TRIM, a);
    rdChk(ADDR_PUMP_CFG, b);
    v = 8'(16'(a) + 16'(b));
    rdChk(ADDR_CHK_LOW, v);
    rdChk(ADDR_CHK_HIGH, 8'((16'(a) + 16'(b)) >> 8));
    // Factory checksum bad: live values stay
    @(negedge ref_clk);
    factoryChkOk = 1'b0;
    i_btcp_host_model.wr(ADDR_BOOST_TRIM, ~a);
    i_btcp_host_model.cycleEnable(ok);
    checkVal(16'(ok), 16'h0001, "reload");
    rdChk(ADDR_BOOST_TRIM, ~a);
    rdChk(ADDR_CHK_LOW, v);
    conclude();
  end
endmodule
`default_nettype wire
